// file: logic/mcg_pkg.sv
// Purpose: Shared constants and types for the master clock generator.
// Assumes: Register bus is AXI4-Lite with 32-bit data.
// Notes: Rates are scaled to one-cycle enables on aclk.
package mcg_pkg;
  localparam int MCG_AW = 4;
  localparam logic [3:0] MCG_OFS_CGC = 4'h0;
  localparam logic [3:0] MCG_OFS_SYS = 4'h4;
  localparam logic [3:0] MCG_OFS_MBC = 4'h8;
  localparam logic [3:0] MCG_OFS_STAT = 4'hc;
  localparam logic [1:0] MCG_RESP_OK = 2'h0;
  localparam logic [1:0] MCG_RESP_SLVERR = 2'h2;
  localparam logic [1:0] MCG_SRC_PLL = 2'h3;
  localparam logic [3:0] MCG_ODIV_MAX = 4'he;
  localparam logic [15:0] MCG_CGC_RST = 16'h0000;
  localparam logic MCG_HALVE_RST = 1'b0;
  localparam logic [1:0] MCG_WS_RST = 2'h1;
  localparam logic [15:0] MCG_NCO_STEP = 16'h0010;
  localparam logic [15:0] MCG_BAND0_LO = 16'h0800;
  localparam logic [15:0] MCG_BAND1_LO = 16'h1000;
  localparam logic [15:0] MCG_BAND2_LO = 16'h1800;
  localparam logic [15:0] MCG_BAND2_HI = 16'h2000;

  // Field order low to high: src, input div, output div, mult, band
  typedef struct packed {
    logic [1:0] vco_band_select;
    logic [5:0] feedback_multiplier;
    logic [3:0] output_divider;
    logic [1:0] input_divider;
    logic [1:0] clock_source_select;
  } mcg_cgc_t;

  typedef enum logic [2:0] {
    MCG_FL_IDLE = 3'b001,
    MCG_FL_WAIT = 3'b010,
    MCG_FL_DONE = 3'b100
  } mcg_fl_state_t;

  // Reserved band code behaves as the lowest band
  function automatic logic [15:0] mcg_band_lo(input logic [1:0] band);
    case (band)
      2'h1: mcg_band_lo = MCG_BAND1_LO;
      2'h2: mcg_band_lo = MCG_BAND2_LO;
      default: mcg_band_lo = MCG_BAND0_LO;
    endcase
  endfunction

  function automatic logic [15:0] mcg_band_hi(input logic [1:0] band);
    case (band)
      2'h1: mcg_band_hi = MCG_BAND2_LO;
      2'h2: mcg_band_hi = MCG_BAND2_HI;
      default: mcg_band_hi = MCG_BAND1_LO;
    endcase
  endfunction
endpackage

// file: logic/mcg_top.sv
// Purpose: Master, CPU and system clock enables plus flash wait states.
// Assumes: Oscillator pin is slower than half of aclk.
// Notes: Loop is an NCO steered once per divided reference edge.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mcg_top
  import mcg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [MCG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MCG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oscillator_input,
  output logic mc_clk_en,
  output logic mc_clk_level,
  output logic cpu_clk_en,
  output logic ebc_clk_en,
  output logic sys_clk_en,
  output logic pll_locked,
  input wire logic flash_req,
  input wire logic flash_seq,
  output logic flash_ready,
  output logic flash_ack
);

  // Register index: 0..3 mapped, 4 for unmapped
  function automatic logic [2:0] reg_sel(input logic [MCG_AW-1:0] a);
    case (a)
      MCG_OFS_CGC: reg_sel = 3'h0;
      MCG_OFS_SYS: reg_sel = 3'h1;
      MCG_OFS_MBC: reg_sel = 3'h2;
      MCG_OFS_STAT: reg_sel = 3'h3;
      default: reg_sel = 3'h4;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  mcg_cgc_t cgc_reg;
  logic halve_reg;
  logic [1:0] ws_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_go;
  logic rd_go;
  logic [2:0] wsel;
  logic [31:0] cgc_merged;
  mcg_cgc_t cgc_next;
  logic [31:0] stat_word;

  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic osc_rise;
  logic pll_act_reg;
  logic halve_act_reg;
  logic cpu_ph_reg;
  logic [5:0] byp_cnt_reg;
  logic [5:0] byp_lim;
  logic byp_tick;
  logic [15:0] acc_reg;
  logic [16:0] acc_sum;
  logic vco_tick;
  logic [15:0] inc_reg;
  logic [15:0] inc_up;
  logic [15:0] inc_dn;
  logic [3:0] k_cnt_reg;
  logic pll_tick;
  logic [1:0] ref_cnt_reg;
  logic ref_tick;
  logic [7:0] vco_cnt_reg;
  logic [7:0] vco_target;
  logic mc_raw;
  logic cpu_raw;
  logic mc_en_reg;
  logic mc_lvl_reg;
  logic cpu_en_reg;
  logic locked_reg;
  logic pass_thru;

  mcg_fl_state_t fl_state_reg;
  logic [2:0] fl_cnt_reg;
  logic [2:0] fl_need_reg;
  logic fl_ack_reg;

  // Register bus: address and data are taken together, one at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign wsel = reg_sel(s_axi_awaddr);
  assign cgc_merged = merge({16'h0000, cgc_reg}, s_axi_wdata, s_axi_wstrb);

  always_comb
  begin
    cgc_next = mcg_cgc_t'(cgc_merged[15:0]);
    if (cgc_next.output_divider > MCG_ODIV_MAX)
      cgc_next.output_divider = MCG_ODIV_MAX;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cgc_reg <= mcg_cgc_t'(MCG_CGC_RST);
      halve_reg <= MCG_HALVE_RST;
      ws_reg <= MCG_WS_RST;
    end
    else if (wr_go)
    begin
      case (wsel)
        3'h0: cgc_reg <= cgc_next;
        3'h1: if (s_axi_wstrb[0]) halve_reg <= s_axi_wdata[0];
        3'h2: if (s_axi_wstrb[0]) ws_reg <= s_axi_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= MCG_RESP_OK;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wsel < 3'h3) ? MCG_RESP_OK : MCG_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign stat_word = {inc_reg, 12'h000, fl_state_reg != MCG_FL_IDLE,
                      halve_act_reg, pll_act_reg, locked_reg};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= MCG_RESP_OK;
      rdata_reg <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= MCG_RESP_OK;
      case (reg_sel(s_axi_araddr))
        3'h0: rdata_reg <= {16'h0000, cgc_reg};
        3'h1: rdata_reg <= {31'h0, halve_reg};
        3'h2: rdata_reg <= {30'h0, ws_reg};
        3'h3: rdata_reg <= stat_word;
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= MCG_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // Oscillator pin crossing; the second stage feeds logic, the third only the rising-edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end
    else
    begin
      osc_s1_reg <= oscillator_input;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end
  assign osc_rise = osc_s2_reg && !osc_s3_reg;

  // Bypass prescalers
  assign byp_lim = 6'((7'(cgc_reg.input_divider) + 7'h01) *
                      (7'(cgc_reg.output_divider) + 7'h01) - 7'h01);
  assign byp_tick = osc_rise && (byp_cnt_reg >= byp_lim);
  assign pass_thru = !pll_act_reg && (byp_lim == 6'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      byp_cnt_reg <= 6'h00;
    else if (byp_tick)
      byp_cnt_reg <= 6'h00;
    else if (osc_rise)
      byp_cnt_reg <= byp_cnt_reg + 6'h01;
  end

  // Loop: NCO is the VCO, its carry is one VCO cycle
  assign acc_sum = {1'b0, acc_reg} + {1'b0, inc_reg};
  assign vco_tick = acc_sum[16];
  assign pll_tick = vco_tick && (k_cnt_reg == cgc_reg.output_divider);
  assign ref_tick = osc_rise && (ref_cnt_reg >= cgc_reg.input_divider);
  assign vco_target = {1'b0, cgc_reg.feedback_multiplier} + 8'h01;
  assign inc_up = inc_reg + MCG_NCO_STEP;
  assign inc_dn = inc_reg - MCG_NCO_STEP;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_reg <= 16'h0000;
      k_cnt_reg <= 4'h0;
      ref_cnt_reg <= 2'h0;
    end
    else
    begin
      acc_reg <= acc_sum[15:0];
      // A count left above a lowered divider restarts instead of ticking off-count
      if (pll_tick || k_cnt_reg > cgc_reg.output_divider)
        k_cnt_reg <= 4'h0;
      else if (vco_tick)
        k_cnt_reg <= k_cnt_reg + 4'h1;
      if (ref_tick)
        ref_cnt_reg <= 2'h0;
      else if (osc_rise)
        ref_cnt_reg <= ref_cnt_reg + 2'h1;
    end
  end

  // Frequency is nudged one step per reference edge in loop mode; outside loop mode it is loaded with the band low end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inc_reg <= MCG_BAND0_LO;
      vco_cnt_reg <= 8'h00;
      locked_reg <= 1'b0;
    end
    else if (cgc_reg.clock_source_select != MCG_SRC_PLL)
    begin
      inc_reg <= mcg_band_lo(cgc_reg.vco_band_select);
      vco_cnt_reg <= 8'h00;
      locked_reg <= 1'b0;
    end
    else if (ref_tick)
    begin
      vco_cnt_reg <= {7'h00, vco_tick};
      locked_reg <= (vco_cnt_reg == vco_target);
      if (inc_reg < mcg_band_lo(cgc_reg.vco_band_select))
        inc_reg <= inc_up;
      else if (inc_reg > mcg_band_hi(cgc_reg.vco_band_select))
        inc_reg <= inc_dn;
      else if (vco_cnt_reg < vco_target && inc_up <= mcg_band_hi(cgc_reg.vco_band_select))
        inc_reg <= inc_up;
      else if (vco_cnt_reg > vco_target && inc_dn >= mcg_band_lo(cgc_reg.vco_band_select))
        inc_reg <= inc_dn;
    end
    else if (vco_tick && vco_cnt_reg != 8'hff)
      vco_cnt_reg <= vco_cnt_reg + 8'h01;
  end

  // Switches land on a tick of the running source, so no runt appears
  assign mc_raw = pll_act_reg ? pll_tick : byp_tick;
  assign cpu_raw = mc_raw && (!halve_act_reg || cpu_ph_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_act_reg <= 1'b0;
      halve_act_reg <= MCG_HALVE_RST;
      cpu_ph_reg <= 1'b0;
    end
    else
    begin
      if (mc_raw)
        pll_act_reg <= (cgc_reg.clock_source_select == MCG_SRC_PLL);
      if (cpu_raw)
      begin
        halve_act_reg <= halve_reg;
        cpu_ph_reg <= 1'b0;
      end
      else if (mc_raw)
        cpu_ph_reg <= !cpu_ph_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mc_en_reg <= 1'b0;
      mc_lvl_reg <= 1'b0;
      cpu_en_reg <= 1'b0;
    end
    else
    begin
      mc_en_reg <= mc_raw;
      mc_lvl_reg <= pass_thru ? osc_s2_reg : mc_raw;
      cpu_en_reg <= cpu_raw;
    end
  end

  assign mc_clk_en = mc_en_reg;
  assign mc_clk_level = mc_lvl_reg;
  assign cpu_clk_en = cpu_en_reg;
  assign ebc_clk_en = cpu_en_reg;
  assign sys_clk_en = cpu_en_reg;
  assign pll_locked = locked_reg;

  // Flash access counted in CPU clocks
  assign flash_ready = (fl_state_reg == MCG_FL_IDLE);
  assign flash_ack = fl_ack_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fl_state_reg <= MCG_FL_IDLE;
      fl_cnt_reg <= 3'h0;
      fl_need_reg <= 3'h0;
      fl_ack_reg <= 1'b0;
    end
    else
    begin
      fl_ack_reg <= 1'b0;
      case (fl_state_reg)
        MCG_FL_IDLE:
          if (flash_req)
          begin
            fl_need_reg <= flash_seq ? 3'h0 : {1'b0, ws_reg};
            fl_cnt_reg <= 3'h0;
            fl_state_reg <= MCG_FL_WAIT;
          end
        MCG_FL_WAIT:
          if (cpu_raw)
          begin
            if (fl_cnt_reg == fl_need_reg)
            begin
              fl_ack_reg <= 1'b1;
              fl_state_reg <= MCG_FL_DONE;
            end
            else
              fl_cnt_reg <= fl_cnt_reg + 3'h1;
          end
        MCG_FL_DONE:
          fl_state_reg <= MCG_FL_IDLE;
        default:
          fl_state_reg <= MCG_FL_IDLE;
      endcase
    end
  end

  // Checking helpers
  logic [3:0] hc_reg;
  logic [2:0] hn_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hc_reg <= 4'h0;
      hn_reg <= 3'h0;
    end
    else if (flash_ready && flash_req)
    begin
      hc_reg <= 4'h0;
      hn_reg <= flash_seq ? 3'h0 : {1'b0, ws_reg};
    end
    else if (cpu_raw && hc_reg != 4'hf)
      hc_reg <= hc_reg + 4'h1;
  end

  // Set by a master tick that brought no CPU tick since the last CPU tick
  logic mt_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mt_reg <= 1'b0;
    else if (cpu_raw)
      mt_reg <= 1'b0;
    else if (mc_raw)
      mt_reg <= 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_byp_divide: assert property (
    !pll_act_reg && mc_raw |-> osc_rise && byp_cnt_reg >= byp_lim)
    else $error("bypass tick off divider count");
  chk_odiv_cap: assert property (
    cgc_reg.output_divider <= MCG_ODIV_MAX)
    else $error("output divider above cap");
  chk_pass_thru: assert property (
    pass_thru && $stable(pass_thru) |=> mc_clk_level == $past(osc_s2_reg))
    else $error("pass-through level not following oscillator");
  chk_pll_kdiv: assert property (
    pll_act_reg && mc_raw |-> vco_tick && k_cnt_reg == cgc_reg.output_divider)
    else $error("loop tick not on K-th VCO cycle");
  chk_loop_gentle: assert property (
    $changed(inc_reg) && cgc_reg.clock_source_select == MCG_SRC_PLL
      && $stable(cgc_reg.vco_band_select)
      |-> inc_reg == $past(inc_reg) + MCG_NCO_STEP
        || inc_reg == $past(inc_reg) - MCG_NCO_STEP)
    else $error("loop frequency jumped");
  chk_cpu_half: assert property (
    halve_act_reg && cpu_raw |-> mt_reg)
    else $error("halved CPU clock ran at master rate");
  chk_cpu_tick: assert property (
    cpu_clk_en |-> $past(mc_raw) && sys_clk_en && ebc_clk_en)
    else $error("CPU enable without master tick");
  chk_flash_wait: assert property (
    flash_ack |-> hc_reg == 4'(hn_reg) + 4'h1 && $past(cpu_raw))
    else $error("flash access length wrong");
  chk_seq_fast: assert property (
    flash_ready && flash_req && flash_seq |=> fl_need_reg == 3'h0)
    else $error("sequential access got wait states");
  chk_switch_edge: assert property (
    $changed(pll_act_reg) || $changed(halve_act_reg) |-> $past(mc_raw))
    else $error("clock switch off a tick");

  cov_pll_lock: cover property (pll_act_reg && $rose(locked_reg));
  cov_half_cpu: cover property (halve_act_reg && cpu_raw);
  cov_flash_ws: cover property (flash_ack && hn_reg == 3'h1);
  cov_seq_flash: cover property (flash_ready && flash_req && flash_seq);

endmodule

// file: tb/master_clock_generation_test.sv
// Purpose: Self-checking bench for the master clock generator.
// Assumes: Oscillator period is exactly ten aclk cycles.
// Notes: Loop rate is judged on an averaged tick count, since the loop jitters.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module master_clock_generation_test
  import mcg_pkg::*;
;
  localparam int OSC_CYC = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [MCG_AW-1:0] s_axi_awaddr = '0;
  logic [MCG_AW-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic flash_req = 1'b0;
  logic flash_seq = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic oscillator_input, mc_clk_en, mc_clk_level, cpu_clk_en, ebc_clk_en, sys_clk_en;
  logic pll_locked, flash_ready, flash_ack;
  int num_errors = 0;
  int compares = 0;
  int bad = 0;
  bit halved = 1'b0;

  always #20 aclk = ~aclk;

  mcg_osc_model osc (.oscillator_input);

  mcg_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillator_input, .mc_clk_en,
    .mc_clk_level, .cpu_clk_en, .ebc_clk_en, .sys_clk_en, .pll_locked, .flash_req,
    .flash_seq, .flash_ready, .flash_ack
  );

  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("wrong value %s exp done got timeout", nm);
    final_report();
  endtask

  task automatic axi_wr(input logic [MCG_AW-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n >= 50)
      hang("write response");
    // One edge between calls, so bready is never assigned twice in one step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [MCG_AW-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50)
      hang("read data");
    @(posedge aclk);
  endtask

  task automatic wr(input logic [MCG_AW-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK("write resp", MCG_RESP_OK, r);
  endtask

  task automatic rd_chk(input logic [MCG_AW-1:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("read resp", MCG_RESP_OK, r);
    `CHK(nm, e, d);
  endtask

  // Cycles from one tick to the next; also watches the derived clocks agree
  task automatic gap(input bit cpu, output int c);
    int n;
    n = 0;
    c = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while ((cpu ? cpu_clk_en : mc_clk_en) !== 1'b1 && n < 2000);
    do
    begin
      @(posedge aclk);
      c++;
      if (ebc_clk_en !== cpu_clk_en || sys_clk_en !== cpu_clk_en)
        bad++;
      if (!halved && cpu_clk_en !== mc_clk_en)
        bad++;
    end
    while ((cpu ? cpu_clk_en : mc_clk_en) !== 1'b1 && c < 2000);
    if (c >= 2000)
      hang("clock tick");
  endtask

  task automatic t_reset();
    logic [1:0] r;
    rd_chk(MCG_OFS_CGC, {16'h0, MCG_CGC_RST}, "cgc reset");
    rd_chk(MCG_OFS_SYS, {31'h0, MCG_HALVE_RST}, "sys reset");
    rd_chk(MCG_OFS_MBC, {30'h0, MCG_WS_RST}, "mbc reset");
    axi_wr(MCG_OFS_STAT, 32'hffff_ffff, r);
    `CHK("status write refused", MCG_RESP_SLVERR, r);
    `CHK("flash idle", 1'b1, flash_ready);
    `CHK("lock pin", 1'b0, pll_locked);
  endtask

  task automatic t_bypass();
    mcg_cgc_t cfg;
    int c;
    int lvl_bad;
    logic [2:0] h;
    logic [1:0] idv [3] = '{2'h1, 2'h3, 2'h0};
    logic [3:0] odv [3] = '{4'h2, 4'hf, 4'h0};
    for (int i = 0; i < 3; i++)
    begin
      cfg = '0;
      cfg.input_divider = idv[i];
      cfg.output_divider = odv[i];
      wr(MCG_OFS_CGC, {16'h0, cfg});
      // An out-of-range output divider is stored as the largest legal one
      if (odv[i] == 4'hf)
        cfg.output_divider = MCG_ODIV_MAX;
      rd_chk(MCG_OFS_CGC, {16'h0, cfg}, "cgc readback");
      gap(1'b0, c);
      gap(1'b0, c);
      `CHK("master gap", OSC_CYC * (idv[i] + 1) * (cfg.output_divider + 1), c);
    end
    lvl_bad = 0;
    h = 3'h0;
    for (int k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (k > 3 && mc_clk_level !== h[2])
        lvl_bad++;
      h = {h[1:0], oscillator_input};
    end
    `CHK("level follows oscillator", 0, lvl_bad);
  endtask

  task automatic t_halve();
    int c;
    bad = 0;
    wr(MCG_OFS_SYS, 32'h1);
    halved = 1'b1;
    rd_chk(MCG_OFS_SYS, 32'h1, "sys readback");
    gap(1'b1, c);
    gap(1'b1, c);
    `CHK("cpu gap halved", 2 * OSC_CYC, c);
    wr(MCG_OFS_SYS, 32'h0);
    gap(1'b1, c);
    gap(1'b1, c);
    halved = 1'b0;
    gap(1'b1, c);
    `CHK("cpu gap full", OSC_CYC, c);
    `CHK("derived clocks agree", 0, bad);
  endtask

  task automatic t_loop();
    mcg_cgc_t cfg;
    logic [31:0] st;
    logic [1:0] r;
    logic [15:0] prev;
    int n;
    int jumps;
    int cnt;
    int expn;
    logic [1:0] idv [2] = '{2'h1, 2'h3};
    logic [5:0] mul [2] = '{6'h0, 6'h1};
    logic [3:0] odv [2] = '{4'h1, 4'h0};
    for (int i = 0; i < 2; i++)
    begin
      cfg = '0;
      cfg.clock_source_select = MCG_SRC_PLL;
      cfg.input_divider = idv[i];
      cfg.feedback_multiplier = mul[i];
      cfg.output_divider = odv[i];
      wr(MCG_OFS_CGC, {16'h0, cfg});
      n = 0;
      jumps = 0;
      do
      begin
        axi_rd(MCG_OFS_STAT, st, r);
        if (n > 0 && (st[31:16] > prev + MCG_NCO_STEP || prev > st[31:16] + MCG_NCO_STEP))
          jumps++;
        if (st[31:16] < MCG_BAND0_LO || st[31:16] > MCG_BAND1_LO)
          jumps++;
        prev = st[31:16];
        n++;
      end
      while (st[1:0] !== 2'h3 && n < 3000);
      if (n >= 3000)
        hang("loop lock");
      `CHK("loop steps and band", 0, jumps);
      // Lock only says the last count matched; the loop still creeps up from band low
      repeat (20000) @(posedge aclk);
      cnt = 0;
      repeat (4000)
      begin
        @(posedge aclk);
        if (mc_clk_en === 1'b1)
          cnt++;
      end
      expn = 4000 * (mul[i] + 1) / (OSC_CYC * (idv[i] + 1) * (odv[i] + 1));
      `CHK("loop tick count", 1'b1, cnt >= expn - 3 && cnt <= expn + 3);
    end
    wr(MCG_OFS_CGC, 32'h0);
    gap(1'b0, n);
    gap(1'b0, n);
    `CHK("back to bypass", OSC_CYC, n);
    `CHK("lock pin bypass", 1'b0, pll_locked);
  endtask

  task automatic t_flash();
    int n;
    int ticks;
    int busy;
    for (int w = 0; w < 4; w++)
      for (int s = 0; s < 2; s++)
      begin
        wr(MCG_OFS_MBC, 32'(w));
        flash_seq <= s[0];
        flash_req <= 1'b1;
        n = 0;
        do
        begin
          @(posedge aclk);
          n++;
        end
        while (flash_ready !== 1'b1 && n < 100);
        flash_req <= 1'b0;
        ticks = 0;
        busy = 0;
        n = 0;
        do
        begin
          @(posedge aclk);
          n++;
          // The first enable seen stems from the take edge, which is not counted
          if (n > 1 && cpu_clk_en === 1'b1)
            ticks++;
          if (flash_ready !== 1'b0)
            busy++;
        end
        while (flash_ack !== 1'b1 && n < 200);
        if (n >= 200)
          hang("flash ack");
        `CHK("flash cpu ticks", s ? 1 : w + 1, ticks);
        `CHK("ack on cpu tick", 1'b1, cpu_clk_en);
        `CHK("flash busy", 0, busy);
      end
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bypass();
    t_halve();
    t_loop();
    t_flash();
    final_report();
  end
endmodule

// file: tb/mcg_osc_model.sv
// Purpose: Free-running external oscillator driving the clock pin.
// Assumes: A crystal never stops, so the pin is driven from time zero and toggles from 213 ns on.
// Notes: The phase offset keeps its edges clear of aclk edges.
`timescale 1ns/1ps
module mcg_osc_model #(
  parameter int HALF_NS = 200,
  parameter int PHASE_NS = 13
) (
  output logic oscillator_input
);
  initial
  begin
    oscillator_input = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) oscillator_input = ~oscillator_input;
  end
endmodule
